// ---- inc/dbc_pkg.sv ----
// ----------------------------------------------------------------------------
// debug bus comparator configuration: shared constants and carriers
// ----------------------------------------------------------------------------
package dbc_pkg;

    // ------------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int REG_AW = 9;
    localparam int REG_DW = 8;

    // ------------------------------------------------------------------------
    // register offsets, byte addressed
    // ------------------------------------------------------------------------
    localparam logic [8:0] OFS_A_MASK_TOP = 9'h11C;
    localparam logic [8:0] OFS_A_MASK_BOTTOM = 9'h11F;
    localparam logic [8:0] OFS_B_CTL = 9'h120;
    localparam logic [8:0] OFS_B_ADDR_HIGH = 9'h125;
    localparam logic [8:0] OFS_B_ADDR_MID = 9'h126;
    localparam logic [8:0] OFS_B_ADDR_LOW = 9'h127;
    localparam logic [8:0] OFS_C_CTL = 9'h130;

    // ------------------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------------------
    localparam int BIT_INVERT = 6;
    localparam int BIT_INSTRUCTION_SELECT = 5;
    localparam int BIT_DIR = 3;
    localparam int BIT_DIRQ = 2;
    localparam int BIT_EN = 0;

    // implemented bits; the rest read as zero
    localparam logic [7:0] B_CTL_WMASK = 8'((1 << BIT_INSTRUCTION_SELECT) | (1 << BIT_DIR)
        | (1 << BIT_DIRQ) | (1 << BIT_EN));
    localparam logic [7:0] C_CTL_WMASK = 8'(B_CTL_WMASK | (1 << BIT_INVERT));

    // ------------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------------
    localparam logic [31:0] RST_A_MASK = 32'h0000_0000;
    localparam logic [7:0] RST_CTL = 8'h00;
    localparam logic [23:0] RST_B_ADDR = 24'h00_0000;
    localparam logic [7:0] RST_RDATA = 8'h00;

    // ------------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic rsv7;
        logic invert_data_match;
        logic instruction_select;
        logic rsv4;
        logic direction_value;          // 1 read, 0 write
        logic direction_qualify_enable;
        logic rsv1;
        logic comparator_enable;
    } dbc_ctl_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;        // data access address
        logic [DATA_W-1:0] data;
        logic read;                     // 1 read, 0 write
        logic valid;                    // data access this cycle
        logic [ADDR_W-1:0] pc_addr;     // instruction at execution stage
        logic pc_valid;
    } dbc_bus_t;

endpackage : dbc_pkg

// ---- verilog/dbc_match.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// one address comparator with optional masked data term
// ----------------------------------------------------------------------------
module dbc_match #(
    parameter int ADDR_W = dbc_pkg::ADDR_W,
    parameter int DATA_W = dbc_pkg::DATA_W,
    parameter bit USE_DATA = 1'b0
) (
    // configuration
    input wire dbc_pkg::dbc_ctl_t i_ctl,
    input wire logic [ADDR_W-1:0] i_cmp_addr,
    input wire logic [DATA_W-1:0] i_cmp_data,
    input wire logic [DATA_W-1:0] i_cmp_mask,
    // observed bus
    input wire dbc_pkg::dbc_bus_t i_bus,
    // result
    output logic o_hit
);

    logic [DATA_W-1:0] bit_differs;
    logic data_ok;
    logic dir_ok;

    // per-bit difference, only positions with the mask bit set count
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_bit
            assign bit_differs[gi] = i_cmp_mask[gi]
                & (i_bus.data[gi] ^ i_cmp_data[gi]);
        end
    endgenerate

    // equality or, when inverted, difference of the masked data
    assign data_ok = !USE_DATA || ((|bit_differs) == i_ctl.invert_data_match);

    // direction term only while qualification is on
    assign dir_ok = !i_ctl.direction_qualify_enable
        || (i_ctl.direction_value == i_bus.read);

    // instruction mode looks at pc only; data and direction drop out
    always_comb begin
        if (!i_ctl.comparator_enable) begin
            o_hit = 1'b0;
        end else if (i_ctl.instruction_select) begin
            o_hit = i_bus.pc_valid && (i_bus.pc_addr == i_cmp_addr);
        end else begin
            o_hit = i_bus.valid && (i_bus.addr == i_cmp_addr) && dir_ok && data_ok;
        end
    end

endmodule : dbc_match

// ---- verilog/dbc_top.sv ----
// Chosen here: strobed register access.
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// debug bus comparator configuration top
// ----------------------------------------------------------------------------
module dbc_top #(
    parameter int ADDR_W = dbc_pkg::ADDR_W,
    parameter int DATA_W = dbc_pkg::DATA_W
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,

    // register port, read data one cycle after the strobe
    input wire logic [dbc_pkg::REG_AW-1:0] i_reg_addr,
    input wire logic [dbc_pkg::REG_DW-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [dbc_pkg::REG_DW-1:0] o_reg_rdata,
    output logic o_wr_refused,

    // debug unit state
    input wire logic i_debug_unit_armed,
    input wire logic i_trace_active_flag,

    // comparator A pairing, held elsewhere
    input wire logic i_pair_ab_range_mode,
    input wire dbc_pkg::dbc_ctl_t i_comparator_a_control,
    input wire logic [DATA_W-1:0] i_comparator_a_data,

    // comparator C values, held elsewhere
    input wire logic [ADDR_W-1:0] i_comparator_c_address,
    input wire logic [DATA_W-1:0] i_comparator_c_data,
    input wire logic [DATA_W-1:0] i_comparator_c_mask,

    // observed processor bus
    input wire dbc_pkg::dbc_bus_t i_bus,

    // match results
    output logic o_comparator_a_data_hit,
    output logic o_match_b,
    output logic o_match_c
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------

    typedef struct packed {
        logic [DATA_W-1:0] a_mask;
        dbc_pkg::dbc_ctl_t b_ctl;
        logic [ADDR_W-1:0] b_addr;
        dbc_pkg::dbc_ctl_t c_ctl;
        logic [dbc_pkg::REG_DW-1:0] rdata;
        logic wr_refused;
        logic a_hit;
        logic match_b;
        logic match_c;
    } dbc_state_t;

    dbc_state_t state;
    dbc_state_t next_state;

    // ------------------------------------------------------------------------
    // combinational helpers
    // ------------------------------------------------------------------------

    logic wr_open;
    logic [1:0] mask_byte;
    logic in_mask_window;
    dbc_pkg::dbc_ctl_t b_ctl_eff;
    logic hit_b;
    logic hit_c;
    logic a_differs;

    // configuration is frozen while armed or tracing, so the comparators
    // never see a half-written setup mid-session
    assign wr_open = !i_debug_unit_armed && !i_trace_active_flag;

    // mask window decode: four consecutive bytes
    assign in_mask_window = (i_reg_addr >= dbc_pkg::OFS_A_MASK_TOP)
        && (i_reg_addr <= dbc_pkg::OFS_A_MASK_BOTTOM);
    assign mask_byte = 2'(i_reg_addr - dbc_pkg::OFS_A_MASK_TOP);

    // in range mode comparator A control steers comparator B; B's own
    // control register keeps its value but has no effect
    assign b_ctl_eff = i_pair_ab_range_mode ? i_comparator_a_control : state.b_ctl;

    // comparator A masked data compare; the address and the rest of A
    // live outside this block
    assign a_differs = |((i_bus.data ^ i_comparator_a_data) & state.a_mask);

    // ------------------------------------------------------------------------
    // register map behaviour
    // ------------------------------------------------------------------------

    // every register is one byte wide on the port; wider values are split
    // into byte lanes that software writes one at a time, top lane first
    // by address, and each lane lands on its own with no holding latch
    // hazard: a multi-byte update is not atomic, so software must finish
    // the whole value before arming, or the comparator sees a blend
    // of old and new lanes for the cycles in between
    // a refused write drops the whole byte and raises the refusal pulse,
    // whatever the address, so software can tell a lost setup from a
    // write to an unmapped place, which is dropped silently
    // reserved control bits are masked at write time rather than at read
    // time, so the stored value and the value that steers the comparators
    // are the same, except for comparator B in range mode, which comparator A control steers
    // trade-off: the mask window is decoded by range rather than by four
    // separate case items, which keeps the lane arithmetic in one place
    // at the price of a subtractor on the address path

    // ------------------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------------------

    // comparator B: address and direction, no data term
    dbc_match #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W),
        .USE_DATA(1'b0)
    ) u_match_b (
        .i_ctl(b_ctl_eff),
        .i_cmp_addr(state.b_addr),
        .i_cmp_data('0),
        .i_cmp_mask('0),
        .i_bus(i_bus),
        .o_hit(hit_b)
    );

    // comparator C: address plus masked data, optionally inverted
    dbc_match #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W),
        .USE_DATA(1'b1)
    ) u_match_c (
        .i_ctl(state.c_ctl),
        .i_cmp_addr(i_comparator_c_address),
        .i_cmp_data(i_comparator_c_data),
        .i_cmp_mask(i_comparator_c_mask),
        .i_bus(i_bus),
        .o_hit(hit_c)
    );

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------

    // register writes, read mux and match sampling in one place
    always_comb begin
        next_state = state;

        // read data stands for one cycle only, zero otherwise
        next_state.rdata = dbc_pkg::RST_RDATA;
        next_state.wr_refused = 1'b0;

        // writes: accepted only while the debug unit is idle
        if (i_reg_wr && !wr_open) begin
            next_state.wr_refused = 1'b1;
        end else if (i_reg_wr) begin
            if (in_mask_window) begin
                // byte 0 is the top byte, byte 3 the bottom byte
                for (int k = 0; k < 4; k++) begin
                    if (mask_byte == 2'(k)) begin
                        next_state.a_mask[31 - 8 * k -: 8] = i_reg_wdata;
                    end
                end
            end
            unique case (i_reg_addr)
                dbc_pkg::OFS_B_CTL: begin
                    next_state.b_ctl = i_reg_wdata & dbc_pkg::B_CTL_WMASK;
                end
                dbc_pkg::OFS_B_ADDR_HIGH: begin
                    next_state.b_addr[23:16] = i_reg_wdata;
                end
                dbc_pkg::OFS_B_ADDR_MID: begin
                    next_state.b_addr[15:8] = i_reg_wdata;
                end
                dbc_pkg::OFS_B_ADDR_LOW: begin
                    next_state.b_addr[7:0] = i_reg_wdata;
                end
                dbc_pkg::OFS_C_CTL: begin
                    next_state.c_ctl = i_reg_wdata & dbc_pkg::C_CTL_WMASK;
                end
                default: begin
                    // unmapped or mask window, handled above
                end
            endcase
        end

        // reads: always allowed, unmapped reads give zero
        if (i_reg_rd) begin
            if (in_mask_window) begin
                for (int k = 0; k < 4; k++) begin
                    if (mask_byte == 2'(k)) begin
                        next_state.rdata = state.a_mask[31 - 8 * k -: 8];
                    end
                end
            end
            unique case (i_reg_addr)
                dbc_pkg::OFS_B_CTL: begin
                    next_state.rdata = state.b_ctl;
                end
                dbc_pkg::OFS_B_ADDR_HIGH: begin
                    next_state.rdata = state.b_addr[23:16];
                end
                dbc_pkg::OFS_B_ADDR_MID: begin
                    next_state.rdata = state.b_addr[15:8];
                end
                dbc_pkg::OFS_B_ADDR_LOW: begin
                    next_state.rdata = state.b_addr[7:0];
                end
                dbc_pkg::OFS_C_CTL: begin
                    next_state.rdata = state.c_ctl;
                end
                default: begin
                    // keep the mask byte or the zero default
                end
            endcase
        end

        // match outputs registered: one cycle behind the bus, which keeps
        // the 24-bit compare off the consumer's timing path
        next_state.a_hit = i_bus.valid && !a_differs;
        next_state.match_b = hit_b;
        next_state.match_c = hit_c;
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------

    // synchronous reset to documented values
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state.a_mask <= dbc_pkg::RST_A_MASK;
            state.b_ctl <= dbc_pkg::RST_CTL;
            state.b_addr <= dbc_pkg::RST_B_ADDR;
            state.c_ctl <= dbc_pkg::RST_CTL;
            state.rdata <= dbc_pkg::RST_RDATA;
            state.wr_refused <= 1'b0;
            state.a_hit <= 1'b0;
            state.match_b <= 1'b0;
            state.match_c <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------------
    // outputs, straight from the state register
    // ------------------------------------------------------------------------

    assign o_reg_rdata = state.rdata;
    assign o_wr_refused = state.wr_refused;
    assign o_comparator_a_data_hit = state.a_hit;
    assign o_match_b = state.match_b;
    assign o_match_c = state.match_c;

endmodule : dbc_top

// ---- sim/dbc_checker.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// port-level checks on the comparator configuration top
// ----------------------------------------------------------------------------
module dbc_checker (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [dbc_pkg::REG_DW-1:0] o_reg_rdata,
    input wire logic o_wr_refused,
    // debug unit state and pairing
    input wire logic i_debug_unit_armed,
    input wire logic i_trace_active_flag,
    input wire logic i_pair_ab_range_mode,
    input wire dbc_pkg::dbc_ctl_t i_comparator_a_control,
    // bus and results
    input wire dbc_pkg::dbc_bus_t i_bus,
    input wire logic o_comparator_a_data_hit,
    input wire logic o_match_b
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    // write attempt while locked, and a range-mode B term driven by A control
    sequence s_refused_wr;
        i_reg_wr && (i_debug_unit_armed || i_trace_active_flag);
    endsequence
    sequence s_range_live;
        i_pair_ab_range_mode && i_comparator_a_control.comparator_enable;
    endsequence

    refuse_pulse_a: assert property (s_refused_wr |=> o_wr_refused)
        else $error("locked write not flagged");
    refuse_only_a: assert property (!(i_reg_wr && (i_debug_unit_armed
        || i_trace_active_flag)) |=> !o_wr_refused)
        else $error("refusal flag without locked write");
    rdata_idle_a: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00)
        else $error("read data outside read answer cycle");
    range_off_a: assert property (i_pair_ab_range_mode
        && !i_comparator_a_control.comparator_enable |=> !o_match_b)
        else $error("range mode match with comparator off");
    range_instruction_select_a: assert property (s_range_live
        ##0 (i_comparator_a_control.instruction_select && !i_bus.pc_valid) |=> !o_match_b)
        else $error("instruction match without executed pc");
    range_dir_a: assert property (s_range_live ##0 (!i_comparator_a_control.instruction_select
        && i_comparator_a_control.direction_qualify_enable
        && i_bus.read != i_comparator_a_control.direction_value) |=> !o_match_b)
        else $error("match on wrong direction");
    range_idle_a: assert property (s_range_live
        ##0 (!i_comparator_a_control.instruction_select && !i_bus.valid) |=> !o_match_b)
        else $error("data match without access");
    a_hit_idle_a: assert property (!i_bus.valid |=> !o_comparator_a_data_hit)
        else $error("data hit without access");
endmodule : dbc_checker

bind dbc_top dbc_checker i_dbc_checker (.i_clk_sys, .i_sys_rst, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .o_wr_refused, .i_debug_unit_armed, .i_trace_active_flag,
    .i_pair_ab_range_mode, .i_comparator_a_control, .i_bus, .o_comparator_a_data_hit,
    .o_match_b);

// ---- sim/dbc_cpu_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// processor bus stand-in, one access or executed pc per call
// ----------------------------------------------------------------------------
module dbc_cpu_model (
    // clock
    input wire logic i_clk_sys,
    // bus towards the comparators
    output dbc_pkg::dbc_bus_t o_bus
);
    initial o_bus = '0;

    // released lines carry the inverse so a stale value can never match
    task automatic xfer(input logic [23:0] a, input logic [31:0] d, input logic r,
        input logic pc);
        @(posedge i_clk_sys);
        o_bus <= '{addr: a, data: d, read: r, valid: !pc, pc_addr: a, pc_valid: pc};
        @(posedge i_clk_sys);
        o_bus <= '{addr: ~a, data: ~d, read: !r, valid: 1'b0, pc_addr: ~a, pc_valid: 1'b0};
    endtask : xfer
endmodule : dbc_cpu_model

// ---- sim/dbc_top_tb.sv ----
`timescale 1ns/1ps
module dbc_top_tb;
    // ------------------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------------------
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [8:0] i_reg_addr = 9'h000;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic debug_armed = 1'b0;
    logic trace_on = 1'b0;
    logic range_mode = 1'b0;
    dbc_pkg::dbc_ctl_t a_ctl = '0;
    dbc_pkg::dbc_bus_t cpu_bus;
    logic [7:0] o_reg_rdata;
    logic o_wr_refused, o_comparator_a_data_hit, o_match_b, o_match_c;
    int err_total = 0;
    int samples_checked = 0;
    // register map walk: last entry is an unmapped place
    localparam logic [8:0] OFS [10] = '{9'h11C, 9'h11D, 9'h11E, 9'h11F, 9'h120,
        9'h125, 9'h126, 9'h127, 9'h130, 9'h121};
    localparam logic [7:0] WV [10] = '{8'hF0, 8'h0F, 8'hFF, 8'h00, 8'hFF,
        8'h12, 8'h34, 8'h56, 8'hFF, 8'h77};
    localparam logic [7:0] EV [10] = '{8'hF0, 8'h0F, 8'hFF, 8'h00, 8'h2D,
        8'h12, 8'h34, 8'h56, 8'h6D, 8'h00};

    initial forever #2.5 i_clk_sys = ~i_clk_sys;

    dbc_top i_dbc_top (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_wr_refused(o_wr_refused),
        .i_debug_unit_armed(debug_armed), .i_trace_active_flag(trace_on),
        .i_pair_ab_range_mode(range_mode), .i_comparator_a_control(a_ctl),
        .i_comparator_a_data(32'h1234_5678), .i_comparator_c_address(24'h00_ABCD),
        .i_comparator_c_data(32'h0000_00A5), .i_comparator_c_mask(32'h0000_00F0),
        .i_bus(cpu_bus), .o_comparator_a_data_hit(o_comparator_a_data_hit),
        .o_match_b(o_match_b), .o_match_c(o_match_c));
    dbc_cpu_model i_dbc_cpu_model (.i_clk_sys(i_clk_sys), .o_bus(cpu_bus));

    // ------------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // refusal flag is looked at in its single answer cycle
    task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic refused);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
        #1 check("wr_refused", refused, o_wr_refused);
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        #1 check("reg_rdata", exp, o_reg_rdata);
    endtask : rd

    // set controls, run one bus cycle, compare {b, c, a data hit}
    task automatic row(input logic rm, input logic [7:0] ac, bc, cc, input logic [23:0] a,
        input logic [31:0] d, input logic r, pc, input logic [2:0] exp);
        @(posedge i_clk_sys);
        range_mode <= rm;
        a_ctl <= ac;
        wr(dbc_pkg::OFS_B_CTL, bc, 1'b0);
        wr(dbc_pkg::OFS_C_CTL, cc, 1'b0);
        i_dbc_cpu_model.xfer(a, d, r, pc);
        #1 check("match_bc_hit", exp, {o_match_b, o_match_c, o_comparator_a_data_hit});
    endtask : row

    task automatic print_verdict();
        if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        foreach (OFS[i]) rd(OFS[i], 8'h00);
        foreach (OFS[i]) wr(OFS[i], WV[i], 1'b0);
        foreach (OFS[i]) rd(OFS[i], EV[i]);
        // locked writes by either cause leave the byte alone
        @(posedge i_clk_sys) debug_armed <= 1'b1;
        wr(dbc_pkg::OFS_B_ADDR_HIGH, 8'hAA, 1'b1);
        @(posedge i_clk_sys);
        debug_armed <= 1'b0;
        trace_on <= 1'b1;
        wr(dbc_pkg::OFS_C_CTL, 8'h00, 1'b1);
        @(posedge i_clk_sys) trace_on <= 1'b0;
        rd(dbc_pkg::OFS_B_ADDR_HIGH, 8'h12);
        rd(dbc_pkg::OFS_C_CTL, 8'h6D);
        row(0, 8'h00, 8'h01, 8'h00, 24'h123456, 32'h1F34_56AB, 0, 0, 3'b101);
        row(0, 8'h00, 8'h01, 8'h00, 24'h123457, 32'h1F34_56AB, 0, 0, 3'b001);
        row(0, 8'h00, 8'h0D, 8'h00, 24'h123456, 32'h0000_0000, 0, 0, 3'b000);
        row(0, 8'h00, 8'h0D, 8'h00, 24'h123456, 32'h0000_0000, 1, 0, 3'b100);
        row(0, 8'h00, 8'h05, 8'h00, 24'h123456, 32'h0000_0000, 0, 0, 3'b100);
        row(0, 8'h00, 8'h09, 8'h00, 24'h123456, 32'h0000_0000, 0, 0, 3'b100);
        row(0, 8'h00, 8'h00, 8'h00, 24'h123456, 32'h0000_0000, 0, 0, 3'b000);
        row(0, 8'h00, 8'h21, 8'h00, 24'h123456, 32'h0000_0000, 0, 0, 3'b000);
        row(0, 8'h00, 8'h2D, 8'h00, 24'h123456, 32'h0000_0000, 0, 1, 3'b100);
        row(0, 8'h00, 8'h00, 8'h01, 24'h00ABCD, 32'h0000_00A5, 0, 0, 3'b010);
        row(0, 8'h00, 8'h00, 8'h01, 24'h00ABCD, 32'h0000_0095, 0, 0, 3'b000);
        row(0, 8'h00, 8'h00, 8'h01, 24'h00ABCD, 32'h0000_00AF, 0, 0, 3'b010);
        row(0, 8'h00, 8'h00, 8'h41, 24'h00ABCD, 32'h0000_0095, 0, 0, 3'b010);
        row(0, 8'h00, 8'h00, 8'h41, 24'h00ABCD, 32'h0000_00A5, 0, 0, 3'b000);
        row(0, 8'h00, 8'h00, 8'h61, 24'h00ABCD, 32'h0000_0095, 0, 1, 3'b010);
        row(0, 8'h00, 8'h00, 8'h0D, 24'h00ABCD, 32'h0000_00A5, 0, 0, 3'b000);
        row(1, 8'h00, 8'h01, 8'h00, 24'h123456, 32'h1F34_56AB, 0, 0, 3'b001);
        row(1, 8'h01, 8'h00, 8'h00, 24'h123456, 32'h1F34_56AB, 0, 0, 3'b101);
        row(1, 8'h0D, 8'h01, 8'h00, 24'h123456, 32'h1F34_56AB, 0, 0, 3'b001);
        row(1, 8'h21, 8'h01, 8'h00, 24'h123456, 32'h1F34_56AB, 0, 0, 3'b001);
        // second reset in mid-run clears the stored address
        @(posedge i_clk_sys) i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        rd(dbc_pkg::OFS_B_ADDR_MID, 8'h00);
        print_verdict();
    end

    // whole run is a few hundred cycles; this bounds a hang
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        err_total++;
        print_verdict();
    end
endmodule : dbc_top_tb
